// file: verification/sdp_host_model.sv
`timescale 1ns/10ps
module sdp_host_model
  import sdp_pkg::*;
(
  input  wire logic  core_clk_i,
  input  wire logic  resetn_i,
  input  wire logic  go_i,
  input  wire logic  fwd_i,
  output sdp_ref_type ref_o
);
  // ------------------------------------------
  // reference source
  // ------------------------------------------
  // each step qualifies the sense
  // sense wobbles between steps so it cannot be trusted without a step
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ref_o <= '0;
    end else begin
      ref_o.step    <= go_i;
      ref_o.forward <= go_i ? fwd_i : !ref_o.forward;
    end
  end
endmodule // sdp_host_model

// file: verification/sdp_top_chk.sv
`timescale 1ns/10ps
module sdp_chk
  import sdp_pkg::*;
(
  input wire logic         core_clk_i,
  input wire logic         resetn_i,
  input wire logic         avs_read_i,
  input wire logic         avs_write_i,
  input wire logic         avs_waitrequest_o,
  input wire sdp_ref_type  ref_i,
  input wire logic         forward_travel_inhibit_i,
  input wire logic         reverse_travel_inhibit_i,
  input wire logic         motor_step_o,
  input wire sdp_quad_type divided_out_o,
  input wire logic         drive_enable_o,
  input wire logic         pitch_alarm_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  logic blk;
  assign blk = ref_i.forward ? forward_travel_inhibit_i
                             : reverse_travel_inhibit_i;
  chk_req_answer: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus request not answered");
  chk_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  chk_step_cause: assert property (
    motor_step_o |-> $past(ref_i.step) && $past(drive_enable_o))
    else $error("step without enabled reference");
  chk_fwd_block: assert property (
    ref_i.step && ref_i.forward && forward_travel_inhibit_i |=> !motor_step_o)
    else $error("step passed forward inhibit");
  chk_rev_block: assert property (
    ref_i.step && !ref_i.forward && reverse_travel_inhibit_i |=> !motor_step_o)
    else $error("step passed reverse inhibit");
  chk_step_taken: assert property (
    ref_i.step && drive_enable_o && !blk |=> motor_step_o)
    else $error("step lost");
  chk_quad_fwd: assert property (
    motor_step_o && $past(ref_i.forward) |-> divided_out_o ==
      {$past(divided_out_o.phase_b), !$past(divided_out_o.phase_a)})
    else $error("forward phase order wrong");
  chk_quad_rev: assert property (
    motor_step_o && !$past(ref_i.forward) |-> divided_out_o ==
      {!$past(divided_out_o.phase_b), $past(divided_out_o.phase_a)})
    else $error("reverse phase order wrong");
  chk_quad_hold: assert property (
    !motor_step_o |-> $stable(divided_out_o))
    else $error("phases moved without a step");
  chk_alarm_gate: assert property (
    pitch_alarm_o && $past(pitch_alarm_o) |-> !drive_enable_o)
    else $error("drive enabled during alarm");
  cov_burst: cover property (motor_step_o ##1 motor_step_o);
  cov_alarm_clear: cover property (pitch_alarm_o ##1 !pitch_alarm_o);
  cov_inhibit: cover property (ref_i.step && blk && drive_enable_o);
endmodule // sdp_chk

bind sdp_top sdp_chk u_chk (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o), .ref_i(ref_i),
  .forward_travel_inhibit_i(forward_travel_inhibit_i),
  .reverse_travel_inhibit_i(reverse_travel_inhibit_i),
  .motor_step_o(motor_step_o), .divided_out_o(divided_out_o),
  .drive_enable_o(drive_enable_o), .pitch_alarm_o(pitch_alarm_o));

// file: verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import sdp_pkg::*;
  logic               core_clk_i = 1'b0, resetn_i = 1'b0;
  logic [ADDR_W-1:0]  adr = '0;
  logic               rd = 1'b0, wr = 1'b0, go = 1'b0, fwd = 1'b0;
  logic [DATA_W-1:0]  wdat = '0, rdat;
  logic               wreq, stp, ccw, den, alarm, irq;
  logic               finh = 1'b0, rinh = 1'b0, conv = 1'b1, pval = 1'b0;
  logic [PITCH_W-1:0] epit = '0, pit;
  sdp_ref_type        ref_w;
  sdp_quad_type       quad;
  logic [DATA_W-1:0]  rq[$];
  logic [2:0]         sq[$];
  logic [31:0]        seed = 32'h814D;
  logic [1:0]         q = 2'h0;
  logic [3:0]         hit = 4'h0;
  logic               dir = 1'b0, en = 1'b0;
  int                 n_errors = 0, checked = 0;

  always #12.5 core_clk_i = ~core_clk_i;

  sdp_host_model u_host (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .go_i(go), .fwd_i(fwd), .ref_o(ref_w));
  sdp_top DUT (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .ref_i(ref_w),
    .forward_travel_inhibit_i(finh), .reverse_travel_inhibit_i(rinh),
    .motor_linear_i(1'b1), .converter_present_i(conv),
    .enc_pitch_valid_i(pval), .enc_pitch_i(epit), .motor_step_o(stp),
    .motor_ccw_o(ccw), .divided_out_o(quad), .drive_enable_o(den),
    .pitch_alarm_o(alarm), .pitch_o(pit), .irq_o(irq));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    if (rq.size() != 0 || sq.size() != 0) n_errors++;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // a read hands its expected word in d
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    int n;
    @(posedge core_clk_i);
    adr <= a; wr <= w; rd <= !w; wdat <= d;
    if (!w) rq.push_back(d);
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    wr <= 1'b0; rd <= 1'b0;
    if (wreq !== 1'b0) begin
      n_errors++;
      stop_test();
    end
  endtask

  // inhibits are held until the next call, which lies past the edge that samples them only when gap adds a cycle
  task automatic step(input logic f, fi, ri, gap);
    go <= 1'b1; fwd <= f; finh <= fi; rinh <= ri;
    if (en && !(f ? fi : ri)) begin
      q = f ? {q[0], ~q[1]} : {~q[0], q[1]};
      sq.push_back({f ^ dir, q});
    end else if (en) hit = hit | (f ? 4'h2 : 4'h4);
    @(posedge core_clk_i);
    if (gap) begin
      go <= 1'b0;
      @(posedge core_clk_i);
    end
  endtask

  // ----------------------------------------
  // result monitor
  // ----------------------------------------
  always @(posedge core_clk_i) begin
    if (rd && wreq === 1'b0)
      chk(rdat, rq.size() ? rq.pop_front() : 'x);
    if (stp !== 1'b0)
      chk({ccw, quad}, sq.size() ? sq.pop_front() : 'x);
  end

  initial begin
    repeat (20000) @(posedge core_clk_i);
    n_errors++;
    stop_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    bus(0, OFS_STATUS, 32'h7);
    bus(0, OFS_PITCH, 32'h0);
    bus(0, OFS_IRQ_STAT, 32'h1);
    chk(den, 1'b0);
    step(1'b1, 1'b0, 1'b0, 1'b1);
    bus(1, OFS_PITCH, 32'h640001);
    bus(1, OFS_PITCH, 32'h800010);
    bus(0, OFS_PITCH, 32'h0);
    bus(0, OFS_IRQ_STAT, 32'h9);
    bus(1, OFS_PITCH, 32'h640000);
    bus(0, OFS_ACT_PITCH, 32'h0);
    bus(0, OFS_STATUS, 32'hF);
    bus(1, OFS_RESTART, 32'h1);
    repeat (3) @(posedge core_clk_i);
    en = 1'b1;
    bus(0, OFS_STATUS, 32'hE);
    bus(0, OFS_ACT_PITCH, 32'h640000);
    chk(pit, PITCH_MAX);
    chk(den, 1'b1);
    // alarm and refused bits are still pending, so unmasking raises irq
    bus(1, OFS_IRQ_MASK, 32'hF);
    repeat (2) @(posedge core_clk_i);
    chk(irq, 1'b1);
    bus(1, OFS_IRQ_STAT, 32'h9);
    repeat (2) @(posedge core_clk_i);
    chk(irq, 1'b0);
    bus(1, OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge core_clk_i);
    chk(irq, 1'b0);
    for (int d = 0; d < 2; d++) begin
      dir = d[0];
      // phase order is fixed in this bench before direction is set
      bus(1, OFS_CTRL, {31'h0, dir});
      for (int k = 0; k < 12; k++) begin
        seed = lfsr(seed);
        step(seed[0], seed[1] & seed[2], seed[3] & seed[4], 1'b1);
      end
      for (int k = 0; k < 8; k++) step(k[0] ^ k[2], 1'b0, 1'b0, 1'b0);
      go <= 1'b0;
      repeat (3) @(posedge core_clk_i);
    end
    bus(0, OFS_IRQ_STAT, {28'h0, hit});
    epit <= seed[22:0] & 23'h3FFFFF;
    pval <= 1'b1;
    conv <= 1'b0;
    bus(1, OFS_RESTART, 32'h1);
    repeat (3) @(posedge core_clk_i);
    bus(0, OFS_AUTO, {9'h0, epit});
    bus(0, OFS_ACT_PITCH, {9'h0, epit});
    bus(0, OFS_STATUS, 32'hA);
    repeat (2) @(posedge core_clk_i);
    stop_test();
  end
endmodule // tb_top

// file: verilog/sdp_pkg.sv
package sdp_pkg;

  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 32;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL      = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_PITCH     = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_ACT_PITCH = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT  = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK  = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_AUTO      = 5'h18;
  localparam logic [ADDR_W-1:0] OFS_RESTART   = 5'h1C;

  // ---------------------------------------------------------------
  // fields
  // ---------------------------------------------------------------
  localparam int unsigned PITCH_W        = 23;
  localparam logic [PITCH_W-1:0] PITCH_MAX = 23'h640000;
  localparam logic [PITCH_W-1:0] PITCH_RST = 23'h000000;
  localparam int unsigned CTRL_DIR_BIT   = 0;
  localparam int unsigned RESTART_BIT    = 0;
  localparam int unsigned IRQ_W          = 4;
  localparam int unsigned IRQ_ALARM      = 0;
  localparam int unsigned IRQ_FWD_HIT    = 1;
  localparam int unsigned IRQ_REV_HIT    = 2;
  localparam int unsigned IRQ_REFUSED    = 3;
  localparam int unsigned ST_ALARM       = 0;
  localparam int unsigned ST_LINEAR      = 1;
  localparam int unsigned ST_CONVERTER   = 2;
  localparam int unsigned ST_WRITTEN     = 3;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic step;
    logic forward;
  } sdp_ref_type;

  typedef struct packed {
    logic phase_a;
    logic phase_b;
  } sdp_quad_type;

  typedef enum logic [1:0] {
    SDP_Q0,
    SDP_Q1,
    SDP_Q2,
    SDP_Q3
  } sdp_qstate_type;

endpackage

// file: verilog/sdp_quad_gen.sv
`timescale 1ns/10ps
module sdp_quad_gen
  import sdp_pkg::*;
(
  input  wire logic         core_clk_i,
  input  wire logic         resetn_i,
  input  wire sdp_ref_type  ref_i,
  output sdp_quad_type      quad_o
);

  sdp_qstate_type state_reg;
  sdp_qstate_type state_next;

  // ---------------------------------------------------------------
  // quadrature walk
  // ---------------------------------------------------------------
  // forward walks 00-01-11-10 in (a,b), so b rises first
  always_comb begin
    state_next = state_reg;
    if (ref_i.step) begin
      unique case (state_reg)
        SDP_Q0: state_next = ref_i.forward ? SDP_Q1 : SDP_Q3;
        SDP_Q1: state_next = ref_i.forward ? SDP_Q2 : SDP_Q0;
        SDP_Q2: state_next = ref_i.forward ? SDP_Q3 : SDP_Q1;
        SDP_Q3: state_next = ref_i.forward ? SDP_Q0 : SDP_Q2;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= SDP_Q0;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      quad_o <= '0;
    end else begin
      unique case (state_next)
        SDP_Q0: quad_o <= '{phase_a: 1'b0, phase_b: 1'b0};
        SDP_Q1: quad_o <= '{phase_a: 1'b0, phase_b: 1'b1};
        SDP_Q2: quad_o <= '{phase_a: 1'b1, phase_b: 1'b1};
        SDP_Q3: quad_o <= '{phase_a: 1'b1, phase_b: 1'b0};
      endcase
    end
  end

endmodule // sdp_quad_gen

// file: verilog/sdp_top.sv
`timescale 1ns/10ps
module sdp_top
  import sdp_pkg::*;
#(
  parameter int unsigned PW = PITCH_W
)
(
  input  wire logic              core_clk_i,
  input  wire logic              resetn_i,
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [DATA_W-1:0] avs_writedata_i,
  output logic      [DATA_W-1:0] avs_readdata_o,
  output logic                   avs_waitrequest_o,
  input  wire sdp_ref_type       ref_i,
  input  wire logic              forward_travel_inhibit_i,
  input  wire logic              reverse_travel_inhibit_i,
  input  wire logic              motor_linear_i,
  input  wire logic              converter_present_i,
  input  wire logic              enc_pitch_valid_i,
  input  wire logic [PW-1:0]     enc_pitch_i,
  output logic                   motor_step_o,
  output logic                   motor_ccw_o,
  output sdp_quad_type           divided_out_o,
  output logic                   drive_enable_o,
  output logic                   pitch_alarm_o,
  output logic      [PW-1:0]     pitch_o,
  output logic                   irq_o
);

  logic              dir_sel_reg;
  logic [PW-1:0]     pitch_pend_reg;
  logic [PW-1:0]     pitch_act_reg;
  logic [PW-1:0]     auto_pitch_reg;
  logic              pitch_written_reg;
  logic              linear_reg;
  logic              converter_reg;
  logic              alarm_reg;
  logic              restart_reg;
  logic [IRQ_W-1:0]  irq_stat_reg;
  logic [IRQ_W-1:0]  irq_mask_reg;
  logic [IRQ_W-1:0]  irq_set;
  logic [IRQ_W-1:0]  irq_clr;
  logic              wr_take;
  logic              rd_take;
  logic [DATA_W-1:0] rd_value;
  logic              pitch_ok;
  logic              alarm_next;
  logic              inhibit_hit;
  logic              step_ok;
  sdp_ref_type       quad_ref;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  function automatic logic sel(input logic [ADDR_W-1:0] addr,
                               input logic [ADDR_W-1:0] ofs);
    sel = (addr == ofs);
  endfunction

  function automatic logic [DATA_W-1:0] pad(input logic [PW-1:0] v);
    pad = {{(DATA_W-PW){1'b0}}, v};
  endfunction

  // access completes at the edge where waitrequest is seen low
  assign wr_take = avs_write_i && !avs_waitrequest_o;
  assign rd_take = avs_read_i  && !avs_waitrequest_o;

  assign pitch_ok = (avs_writedata_i[DATA_W-1:PW] == '0) &&
                    (avs_writedata_i[PW-1:0] <= PITCH_MAX);

  always_comb begin
    rd_value = '0;
    if (sel(avs_address_i, OFS_CTRL)) begin
      rd_value[CTRL_DIR_BIT] = dir_sel_reg;
    end else if (sel(avs_address_i, OFS_PITCH)) begin
      rd_value = pad(pitch_pend_reg);
    end else if (sel(avs_address_i, OFS_ACT_PITCH)) begin
      rd_value = pad(pitch_o);
    end else if (sel(avs_address_i, OFS_STATUS)) begin
      rd_value[ST_ALARM]     = alarm_reg;
      rd_value[ST_LINEAR]    = linear_reg;
      rd_value[ST_CONVERTER] = converter_reg;
      rd_value[ST_WRITTEN]   = pitch_written_reg;
    end else if (sel(avs_address_i, OFS_IRQ_STAT)) begin
      rd_value[IRQ_W-1:0] = irq_stat_reg;
    end else if (sel(avs_address_i, OFS_IRQ_MASK)) begin
      rd_value[IRQ_W-1:0] = irq_mask_reg;
    end else if (sel(avs_address_i, OFS_AUTO)) begin
      rd_value = pad(auto_pitch_reg);
    end
  end

  // ---------------------------------------------------------------
  // avalon handshake
  // ---------------------------------------------------------------
  // one wait cycle lets read data settle before the master samples
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if (avs_waitrequest_o) begin
      avs_waitrequest_o <= !(avs_read_i || avs_write_i);
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      avs_readdata_o <= '0;
    end else if (avs_read_i && avs_waitrequest_o) begin
      avs_readdata_o <= rd_value;
    end
  end

  // ---------------------------------------------------------------
  // software settings
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dir_sel_reg <= 1'b0;
    end else if (wr_take && sel(avs_address_i, OFS_CTRL)) begin
      dir_sel_reg <= avs_writedata_i[CTRL_DIR_BIT];
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pitch_pend_reg <= PITCH_RST;
    end else if (wr_take && sel(avs_address_i, OFS_PITCH) && pitch_ok) begin
      pitch_pend_reg <= avs_writedata_i[PW-1:0];
    end
  end

  // survives a soft restart so the alarm can clear on the next one
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pitch_written_reg <= 1'b0;
    end else if (wr_take && sel(avs_address_i, OFS_PITCH) && pitch_ok &&
                 (avs_writedata_i[PW-1:0] != pitch_pend_reg)) begin
      pitch_written_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // restart capture
  // ---------------------------------------------------------------
  // pending after reset, so power-up behaves as the first restart
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      restart_reg <= 1'b1;
    end else begin
      restart_reg <= wr_take && sel(avs_address_i, OFS_RESTART) &&
                     avs_writedata_i[RESTART_BIT];
    end
  end

  // straps are sampled on restart, never inside the reset branch
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      linear_reg    <= 1'b0;
      converter_reg <= 1'b0;
    end else if (restart_reg) begin
      linear_reg    <= motor_linear_i;
      converter_reg <= converter_present_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pitch_act_reg <= PITCH_RST;
    end else if (restart_reg) begin
      pitch_act_reg <= pitch_pend_reg;
    end
  end

  assign alarm_next = motor_linear_i && converter_present_i &&
                      !pitch_written_reg;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      alarm_reg <= 1'b0;
    end else if (restart_reg) begin
      alarm_reg <= alarm_next;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      auto_pitch_reg <= PITCH_RST;
    end else if (enc_pitch_valid_i && !converter_reg) begin
      auto_pitch_reg <= enc_pitch_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pitch_o <= PITCH_RST;
    end else begin
      pitch_o <= converter_reg ? pitch_act_reg : auto_pitch_reg;
    end
  end

  // ---------------------------------------------------------------
  // motion path
  // ---------------------------------------------------------------
  // inhibit follows reference sense
  assign inhibit_hit = ref_i.step &&
                       (ref_i.forward ? forward_travel_inhibit_i
                                      : reverse_travel_inhibit_i);

  // no linear motion while pitch invalid
  assign step_ok = ref_i.step && !inhibit_hit && drive_enable_o;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      drive_enable_o <= 1'b0;
    end else begin
      drive_enable_o <= !(linear_reg && alarm_reg) && !restart_reg;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pitch_alarm_o <= 1'b0;
    end else begin
      pitch_alarm_o <= alarm_reg;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      motor_step_o <= 1'b0;
      motor_ccw_o  <= 1'b0;
    end else begin
      motor_step_o <= step_ok;
      if (step_ok) begin
        motor_ccw_o <= ref_i.forward ^ dir_sel_reg;
      end
    end
  end

  // pulses follow the reference, not the select
  assign quad_ref = '{step: step_ok, forward: ref_i.forward};

  sdp_quad_gen u_quad (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .ref_i      (quad_ref),
    .quad_o     (divided_out_o)
  );

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  always_comb begin
    irq_set              = '0;
    irq_set[IRQ_ALARM]   = restart_reg && alarm_next;
    irq_set[IRQ_FWD_HIT] = inhibit_hit && ref_i.forward;
    irq_set[IRQ_REV_HIT] = inhibit_hit && !ref_i.forward;
    irq_set[IRQ_REFUSED] = wr_take && sel(avs_address_i, OFS_PITCH) &&
                           !pitch_ok;
  end

  assign irq_clr = (wr_take && sel(avs_address_i, OFS_IRQ_STAT)) ?
                   avs_writedata_i[IRQ_W-1:0] : '0;

  // a set in the clearing cycle wins
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_mask_reg <= '0;
    end else if (wr_take && sel(avs_address_i, OFS_IRQ_MASK)) begin
      irq_mask_reg <= avs_writedata_i[IRQ_W-1:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end

endmodule // sdp_top
